// File: core/operand_address_field_decoder.sv
// registered decoder for register, address, direction and condition fields
`timescale 1ns/1ns
`default_nettype none
module operand_address_field_decoder
    import opdec_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // from decode stage
    input  wire logic        dec_valid,
    input  wire logic [7:0]  modrm_byte,
    input  wire logic [7:0]  sib_byte,
    input  wire logic        opsize_override,
    input  wire logic        addrsize_override,
    input  wire logic        width_bit,
    input  wire logic        direction_bit,
    input  wire logic        sign_ext_bit,
    input  wire logic [3:0]  cond_field,
    input  wire logic [31:0] imm_raw,
    input  wire logic        imm_is_byte,
    // to address generator
    output logic             out_valid_q,
    output logic             mem_operand_q,
    output logic             sib_used_q,
    output logic             base_valid_q,
    output logic [2:0]       base_reg_q,
    output logic             index_valid_q,
    output logic [2:0]       index_reg_q,
    output logic [1:0]       scale_shift_q,
    output opdec_pkg::disp_e disp_size_q,
    output opdec_pkg::seg_e  default_seg_q,
    output logic             addr_undefined_q,
    // to execute stage
    output logic [2:0]       reg_field_q,
    output logic [1:0]       reg_width_q,
    output logic [2:0]       rm_reg_q,
    output logic             reg_is_dest_q,
    output logic [31:0]      imm_q,
    output opdec_pkg::cond_e cond_test_q,
    output logic             cond_negate_q
);
    // ----------------------------------------
    // field extraction
    // ----------------------------------------
    logic [1:0] mod_f;
    logic [2:0] reg_f;
    logic [2:0] rm_f;
    logic [1:0] ss_f;
    logic [2:0] idx_f;
    logic [2:0] base_f;

    assign mod_f  = modrm_byte[MODRM_MOD_HI -: 2];
    assign reg_f  = modrm_byte[MODRM_REG_HI -: 3];
    assign rm_f   = modrm_byte[MODRM_RM_HI -: 3];
    assign ss_f   = sib_byte[SIB_SS_HI -: 2];
    assign idx_f  = sib_byte[SIB_IDX_HI -: 3];
    assign base_f = sib_byte[SIB_BASE_HI -: 3];

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // general register width from the w bit and the size override
    function automatic logic [1:0] reg_width(input logic w, input logic ovr);
        if (!w) begin
            return WIDTH_8;
        end
        return ovr ? WIDTH_16 : WIDTH_32;
    endfunction

    // 16-bit index from the low r/m bit: source index even, destination odd
    function automatic logic [2:0] idx16_sel(input logic [2:0] rm);
        if (rm[0]) begin
            return REG_DST_IDX;
        end
        return REG_SRC_IDX;
    endfunction

    // ----------------------------------------
    // effective address decode
    // ----------------------------------------
    logic       mem_d;
    logic       sib_d;
    logic       base_v_d;
    logic [2:0] base_d;
    logic       idx_v_d;
    logic [2:0] idx_d;
    logic [1:0] shift_d;
    disp_e      disp_d;
    seg_e       seg_d;
    logic       undef_d;

    always_comb begin
        mem_d    = (mod_f != MOD_REG);
        sib_d    = 1'b0;
        base_v_d = 1'b0;
        base_d   = REG_ACC;
        idx_v_d  = 1'b0;
        idx_d    = REG_ACC;
        shift_d  = SCALE_ONE;
        disp_d   = DISP_NONE;
        undef_d  = 1'b0;
        if (!mem_d) begin
            disp_d = DISP_NONE;
        end else if (addrsize_override) begin
            unique case (mod_f)
                MOD_DISP8:    disp_d = DISP_8;
                MOD_DISPFULL: disp_d = DISP_16;
                default:      disp_d = DISP_NONE;
            endcase
            unique case (rm_f)
                3'h0, 3'h1: begin
                    base_v_d = 1'b1;
                    base_d   = REG_BASE;
                    idx_v_d  = 1'b1;
                    idx_d    = idx16_sel(rm_f);
                end
                3'h2, 3'h3: begin
                    base_v_d = 1'b1;
                    base_d   = REG_FP;
                    idx_v_d  = 1'b1;
                    idx_d    = idx16_sel(rm_f);
                end
                3'h4, 3'h5: begin
                    idx_v_d = 1'b1;
                    idx_d   = idx16_sel(rm_f);
                end
                3'h6: begin
                    if (mod_f == MOD_NODISP) begin
                        disp_d = DISP_16;
                    end else begin
                        base_v_d = 1'b1;
                        base_d   = REG_FP;
                    end
                end
                3'h7: begin
                    base_v_d = 1'b1;
                    base_d   = REG_BASE;
                end
            endcase
        end else begin
            unique case (mod_f)
                MOD_DISP8:    disp_d = DISP_8;
                MOD_DISPFULL: disp_d = DISP_32;
                default:      disp_d = DISP_NONE;
            endcase
            if (rm_f == RM32_SIB) begin
                sib_d   = 1'b1;
                shift_d = ss_f;
                idx_v_d = (idx_f != IDX_NONE);
                idx_d   = idx_f;
                undef_d = (idx_f == IDX_NONE) && (ss_f != SCALE_ONE);
                if (mod_f == MOD_NODISP && base_f == RM32_DISP_ONLY) begin
                    disp_d = DISP_32;
                end else begin
                    base_v_d = 1'b1;
                    base_d   = base_f;
                end
            end else if (mod_f == MOD_NODISP && rm_f == RM32_DISP_ONLY) begin
                disp_d = DISP_32;
            end else begin
                base_v_d = 1'b1;
                base_d   = rm_f;
            end
        end
    end

    // ----------------------------------------
    // default segment
    // ----------------------------------------
    // segment override prefixes are applied downstream; only the default is chosen here
    // frame pointer and stack pointer forms
    always_comb begin
        seg_d = data_segment;
        if (base_v_d && base_d == REG_FP) begin
            seg_d = stack_segment;
        end
        // a 16-bit form never names the stack pointer, so this arm is 32-bit only
        if (!addrsize_override && base_v_d && base_d == REG_SP) begin
            seg_d = stack_segment;
        end
    end

    // ----------------------------------------
    // condition and immediate
    // ----------------------------------------
    cond_e       cond_d;
    logic        neg_d;
    logic [31:0] imm_d;

    cond_field_decoder u_cond (
        .cond_field   (cond_field),
        .cond_test    (cond_d),
        .cond_negate  (neg_d),
        .imm_raw      (imm_raw),
        .imm_is_byte  (imm_is_byte),
        .sign_ext_bit (sign_ext_bit),
        .dest_width   (reg_width(width_bit, opsize_override)),
        .imm_out      (imm_d)
    );

    // ----------------------------------------
    // valid flag
    // ----------------------------------------
    // the valid flag follows dec_valid each cycle; the other outputs hold until the next valid one
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid_q <= 1'b0;
        end else begin
            out_valid_q <= dec_valid;
        end
    end

    // ----------------------------------------
    // address outputs
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_operand_q    <= 1'b0;
            sib_used_q       <= 1'b0;
            base_valid_q     <= 1'b0;
            base_reg_q       <= REG_ACC;
            index_valid_q    <= 1'b0;
            index_reg_q      <= REG_ACC;
            scale_shift_q    <= SCALE_ONE;
            disp_size_q      <= DISP_NONE;
            default_seg_q    <= data_segment;
            addr_undefined_q <= 1'b0;
        end else if (dec_valid) begin
            mem_operand_q    <= mem_d;
            sib_used_q       <= sib_d;
            base_valid_q     <= base_v_d;
            base_reg_q       <= base_d;
            index_valid_q    <= idx_v_d;
            index_reg_q      <= idx_d;
            scale_shift_q    <= shift_d;
            disp_size_q      <= disp_d;
            default_seg_q    <= seg_d;
            addr_undefined_q <= undef_d;
        end
    end

    // ----------------------------------------
    // operand outputs
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_field_q   <= REG_ACC;
            reg_width_q   <= WIDTH_8;
            rm_reg_q      <= REG_ACC;
            reg_is_dest_q <= 1'b0;
        end else if (dec_valid) begin
            // register number with width selected by the w bit and the size override
            reg_field_q   <= reg_f;
            reg_width_q   <= reg_width(width_bit, opsize_override);
            rm_reg_q      <= rm_f;
            reg_is_dest_q <= direction_bit;
        end
    end

    // ----------------------------------------
    // immediate and condition outputs
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            imm_q         <= 32'h00000000;
            cond_test_q   <= COND_OVERFLOW;
            cond_negate_q <= 1'b0;
        end else if (dec_valid) begin
            imm_q         <= imm_d;
            cond_test_q   <= cond_d;
            cond_negate_q <= neg_d;
        end
    end
endmodule
`default_nettype wire

// File: core/opdec_pkg.sv
// constants and types for the operand and address field decoder
package opdec_pkg;

    // register numbers, shared by 16- and 32-bit views
    localparam logic [2:0] REG_ACC       = 3'h0;
    localparam logic [2:0] REG_CNT       = 3'h1;
    localparam logic [2:0] REG_DATA      = 3'h2;
    localparam logic [2:0] REG_BASE      = 3'h3;
    localparam logic [2:0] REG_SP        = 3'h4;
    localparam logic [2:0] REG_FP        = 3'h5;
    localparam logic [2:0] REG_SRC_IDX   = 3'h6;
    localparam logic [2:0] REG_DST_IDX   = 3'h7;

    // operand width codes
    localparam logic [1:0] WIDTH_8       = 2'h0;
    localparam logic [1:0] WIDTH_16      = 2'h1;
    localparam logic [1:0] WIDTH_32      = 2'h2;

    // mode field values
    localparam logic [1:0] MOD_NODISP    = 2'h0;
    localparam logic [1:0] MOD_DISP8     = 2'h1;
    localparam logic [1:0] MOD_DISPFULL  = 2'h2;
    localparam logic [1:0] MOD_REG       = 2'h3;

    // special r/m, base and index codes
    localparam logic [2:0] RM16_DISP_ONLY = 3'h6;
    localparam logic [2:0] RM32_SIB       = 3'h4;
    localparam logic [2:0] RM32_DISP_ONLY = 3'h5;
    localparam logic [2:0] IDX_NONE       = 3'h4;
    localparam logic [1:0] SCALE_ONE      = 2'h0;

    // field positions inside the addressing-form and scaled-index bytes
    localparam int MODRM_MOD_HI = 7;
    localparam int MODRM_REG_HI = 5;
    localparam int MODRM_RM_HI  = 2;
    localparam int SIB_SS_HI    = 7;
    localparam int SIB_IDX_HI   = 5;
    localparam int SIB_BASE_HI  = 2;

    // displacement size
    typedef enum logic [1:0] {
        DISP_NONE = 2'b00,
        DISP_8    = 2'b01,
        DISP_16   = 2'b10,
        DISP_32   = 2'b11
    } disp_e;

    // default segment
    typedef enum logic [0:0] {
        data_segment  = 1'b0,
        stack_segment = 1'b1
    } seg_e;

    // condition tests
    typedef enum logic [2:0] {
        COND_OVERFLOW = 3'b000,
        COND_BELOW    = 3'b001,
        COND_ZERO     = 3'b010,
        COND_BELOW_EQ = 3'b011,
        COND_SIGN     = 3'b100,
        COND_PARITY   = 3'b101,
        COND_LESS     = 3'b110,
        COND_LESS_EQ  = 3'b111
    } cond_e;

endpackage

// File: core/cond_field_decoder.sv
// condition field and immediate extension decode
`timescale 1ns/1ns
`default_nettype none
module cond_field_decoder
    import opdec_pkg::*;
(
    // condition field
    input  wire logic [3:0]  cond_field,
    output opdec_pkg::cond_e cond_test,
    output logic             cond_negate,
    // immediate
    input  wire logic [31:0] imm_raw,
    input  wire logic        imm_is_byte,
    input  wire logic        sign_ext_bit,
    input  wire logic [1:0]  dest_width,
    output logic      [31:0] imm_out
);
    // ----------------------------------------
    // condition
    // ----------------------------------------
    // test and negate
    always_comb begin
        cond_test   = cond_e'(cond_field[3:1]);
        cond_negate = cond_field[0];
    end

    // ----------------------------------------
    // immediate
    // ----------------------------------------
    // byte sign or zero extension, chosen by sign_ext_bit
    always_comb begin
        imm_out = imm_raw;
        if (imm_is_byte && dest_width != WIDTH_8) begin
            if (sign_ext_bit) begin
                imm_out = {{24{imm_raw[7]}}, imm_raw[7:0]};
            end else begin
                imm_out = {24'h000000, imm_raw[7:0]};
            end
            if (dest_width == WIDTH_16) begin
                imm_out[31:16] = 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/decoder_checker.sv
// assertion checker for the operand and address field decoder
`timescale 1ns/1ns
`default_nettype none
module decoder_checker
    import opdec_pkg::*;
(
    // clock and reset
    input wire logic             clk,
    input wire logic             sys_rst,
    // decode inputs
    input wire logic             dec_valid,
    input wire logic [7:0]       modrm_byte,
    input wire logic [7:0]       sib_byte,
    input wire logic             opsize_override,
    input wire logic             addrsize_override,
    input wire logic             width_bit,
    input wire logic             direction_bit,
    input wire logic [3:0]       cond_field,
    // decoded outputs
    input wire logic             sib_used_q,
    input wire logic             base_valid_q,
    input wire logic             index_valid_q,
    input wire logic [2:0]       index_reg_q,
    input wire logic [1:0]       scale_shift_q,
    input wire opdec_pkg::disp_e disp_size_q,
    input wire opdec_pkg::seg_e  default_seg_q,
    input wire logic             addr_undefined_q,
    input wire logic [1:0]       reg_width_q,
    input wire logic             reg_is_dest_q,
    input wire opdec_pkg::cond_e cond_test_q,
    input wire logic             cond_negate_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire logic [1:0] md  = modrm_byte[7:6];
    wire logic [2:0] rm  = modrm_byte[2:0];
    wire logic       a16 = dec_valid && addrsize_override;
    // sib byte only follows a 32-bit memory form with r/m 100
    wire logic       sib_case = dec_valid && !addrsize_override && rm == 3'h4 && md != 2'h3;
    a_reg_word16: assert property (
        dec_valid && opsize_override && width_bit |=> reg_width_q == WIDTH_16)
        else $error("word width missing");
    a_disp_only16: assert property (
        a16 && md == 2'h0 && rm == 3'h6 |=> disp_size_q == DISP_16 && !base_valid_q)
        else $error("bare displacement wrong");
    a_short_disp16: assert property (
        a16 && md == 2'h1 |=> disp_size_q == DISP_8)
        else $error("byte displacement wrong");
    a_stack_seg16: assert property (
        a16 && md != 2'h3 && (rm[2:1] == 2'h1 || (rm == 3'h6 && md != 2'h0))
        |=> default_seg_q == stack_segment)
        else $error("stack segment missing");
    a_disp_only32: assert property (
        sib_case && md == 2'h0 && sib_byte[2:0] == 3'h5 |=> disp_size_q == DISP_32)
        else $error("wide displacement wrong");
    a_scale_copy: assert property (
        sib_case |=> scale_shift_q == $past(sib_byte[7:6]))
        else $error("scale wrong");
    a_index_pick: assert property (
        sib_case |=> index_valid_q == ($past(sib_byte[5:3]) != 3'h4))
        else $error("index valid wrong");
    a_undef_flag: assert property (
        sib_case && sib_byte[5:3] == 3'h4 && sib_byte[7:6] != 2'h0 |=> addr_undefined_q)
        else $error("undefined flag missing");
    a_dir_role: assert property (
        dec_valid |=> reg_is_dest_q == $past(direction_bit))
        else $error("direction wrong");
    a_cond_split: assert property (
        dec_valid |=> cond_test_q == $past(cond_field[3:1])
                      && cond_negate_q == $past(cond_field[0]))
        else $error("condition wrong");
    a_sib_detect: assert property (
        dec_valid |=> sib_used_q == $past(sib_case))
        else $error("sib use wrong");
endmodule
bind operand_address_field_decoder decoder_checker i_decoder_checker (
    .clk, .sys_rst, .dec_valid, .modrm_byte, .sib_byte, .opsize_override,
    .addrsize_override, .width_bit, .direction_bit, .cond_field, .sib_used_q,
    .base_valid_q, .index_valid_q, .index_reg_q, .scale_shift_q, .disp_size_q,
    .default_seg_q, .addr_undefined_q, .reg_width_q, .reg_is_dest_q, .cond_test_q,
    .cond_negate_q);
`default_nettype wire

// File: tb/fetch_model.sv
// fetch stage model presenting one instruction per request
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
    // clock
    input  wire logic   clk,
    // instruction fields
    output logic        dec_valid,
    output logic [7:0]  modrm_byte,
    output logic [7:0]  sib_byte,
    output logic        opsize_override,
    output logic        addrsize_override,
    output logic        width_bit,
    output logic        direction_bit,
    output logic        sign_ext_bit,
    output logic [3:0]  cond_field,
    output logic [31:0] imm_raw,
    output logic        imm_is_byte
);
    initial begin
        {dec_valid, modrm_byte, sib_byte, cond_field, imm_raw, imm_is_byte} = '0;
        {opsize_override, addrsize_override, width_bit, direction_bit, sign_ext_bit} = '0;
    end
    // c packs size, address, width, direction and sign bits; fields are inverted
    // once released, but the bench checks before the next edge, so failure to hold is not caught
    task automatic send(input logic [7:0] m, input logic [7:0] s, input logic [4:0] c,
                        input logic [3:0] cf, input logic [31:0] im, input logic ib);
        @(posedge clk);
        #1;
        {dec_valid, modrm_byte, sib_byte} = {1'b1, m, s};
        {cond_field, imm_raw, imm_is_byte} = {cf, im, ib};
        {opsize_override, addrsize_override, width_bit, direction_bit, sign_ext_bit} = c;
        @(posedge clk);
        #1;
        dec_valid = 1'b0;
        {modrm_byte, sib_byte, cond_field, imm_raw} = ~{modrm_byte, sib_byte, cond_field, imm_raw};
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the operand and address field decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import opdec_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic dec_valid, opsize_override, addrsize_override, width_bit, direction_bit;
    logic sign_ext_bit, imm_is_byte, out_valid_q, mem_operand_q, sib_used_q;
    logic base_valid_q, index_valid_q, addr_undefined_q, reg_is_dest_q, cond_negate_q;
    logic [7:0] modrm_byte, sib_byte;
    logic [3:0] cond_field;
    logic [31:0] imm_raw, imm_q;
    logic [2:0] base_reg_q, index_reg_q, reg_field_q, rm_reg_q;
    logic [1:0] scale_shift_q, reg_width_q;
    disp_e disp_size_q;
    seg_e default_seg_q;
    cond_e cond_test_q;
    int miscompares = 0;
    int checked = 0;
    always #2 clk = ~clk;
    fetch_model i_fetch_model (.clk, .dec_valid, .modrm_byte, .sib_byte, .opsize_override,
        .addrsize_override, .width_bit, .direction_bit, .sign_ext_bit, .cond_field,
        .imm_raw, .imm_is_byte);
    operand_address_field_decoder i_operand_address_field_decoder (.clk, .sys_rst,
        .dec_valid, .modrm_byte, .sib_byte, .opsize_override, .addrsize_override,
        .width_bit, .direction_bit, .sign_ext_bit, .cond_field, .imm_raw, .imm_is_byte,
        .out_valid_q, .mem_operand_q, .sib_used_q, .base_valid_q, .base_reg_q,
        .index_valid_q, .index_reg_q, .scale_shift_q, .disp_size_q, .default_seg_q,
        .addr_undefined_q, .reg_field_q, .reg_width_q, .rm_reg_q, .reg_is_dest_q, .imm_q,
        .cond_test_q, .cond_negate_q);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic go(input logic [7:0] m, input logic [7:0] s, input logic [4:0] c,
                      input logic [3:0] cf, input logic [31:0] im, input logic ib);
        i_fetch_model.send(m, s, c, cf, im, ib);
        chk("out_valid", 1, out_valid_q);
    endtask
    task automatic t_reg16();
        for (int r = 0; r < 8; r++) begin
            go({2'h3, r[2:0], 3'(7 - r)}, 8'h00, 5'b10100, 4'h0, 32'h0, 1'b0);
            chk("reg_width", WIDTH_16, reg_width_q);
            chk("reg_field", r, reg_field_q);
            chk("mem_operand", 0, mem_operand_q);
            chk("rm_reg", 7 - r, rm_reg_q);
        end
        go(8'hc0, 8'h00, 5'b10000, 4'h0, 32'h0, 1'b0);
        chk("reg_width", WIDTH_8, reg_width_q);
    endtask
    task automatic t_ea16();
        logic bx, fp, iv;
        logic [1:0] dz;
        for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 8; r++) begin
                bx = r == 0 || r == 1 || r == 7;
                fp = r == 2 || r == 3 || (r == 6 && m != 0);
                iv = r < 6;
                dz = (m == 1) ? DISP_8 : (m == 2 || r == 6) ? DISP_16 : DISP_NONE;
                go({m[1:0], 3'h0, r[2:0]}, 8'h00, 5'b01100, 4'h0, 32'h0, 1'b0);
                chk("mem_operand", 1, mem_operand_q);
                chk("base_valid", bx | fp, base_valid_q);
                if (bx | fp) chk("base_reg", fp ? REG_FP : REG_BASE, base_reg_q);
                chk("index_valid", iv, index_valid_q);
                if (iv) chk("index_reg", r[0] ? REG_DST_IDX : REG_SRC_IDX, index_reg_q);
                chk("disp", dz, disp_size_q);
                chk("seg", fp, default_seg_q);
            end
        end
    endtask
    task automatic t_ea32();
        logic [1:0] ss, dz;
        logic [2:0] ix;
        logic bv;
        for (int m = 0; m < 3; m++) begin
            for (int b = 0; b < 8; b++) begin
                ss = b[1:0];
                ix = 3'(7 - b);
                bv = !(m == 0 && b == 5);
                dz = (m == 1) ? DISP_8 : (m == 2 || !bv) ? DISP_32 : DISP_NONE;
                go({m[1:0], 3'h1, 3'h4}, {ss, ix, b[2:0]}, 5'b00100, 4'h0, 32'h0, 1'b0);
                chk("sib_used", 1, sib_used_q);
                chk("mem_operand", 1, mem_operand_q);
                chk("base_valid", bv, base_valid_q);
                if (bv) chk("base_reg", b, base_reg_q);
                chk("disp", dz, disp_size_q);
                chk("seg", bv && b[2:1] == 2'h2, default_seg_q);
                chk("scale", ss, scale_shift_q);
                chk("index_valid", ix != IDX_NONE, index_valid_q);
                if (ix != IDX_NONE) chk("index_reg", ix, index_reg_q);
                chk("undefined", ix == IDX_NONE && ss != 2'h0, addr_undefined_q);
            end
        end
        go(8'hc4, 8'h00, 5'b00100, 4'h0, 32'h0, 1'b0);
        chk("sib_used", 0, sib_used_q);
        go(8'h04, 8'h00, 5'b01100, 4'h0, 32'h0, 1'b0);
        chk("sib_used", 0, sib_used_q);
    endtask
    task automatic t_ea32_plain();
        logic bv;
        logic [1:0] dz;
        for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 8; r++) begin
                bv = !(m == 0 && r == 5);
                dz = (m == 1) ? DISP_8 : (m == 2 || !bv) ? DISP_32 : DISP_NONE;
                go({m[1:0], 3'h2, r[2:0]}, 8'h00, 5'b00100, 4'h0, 32'h0, 1'b0);
                chk("sib_used", r == 4, sib_used_q);
                if (r != 4) begin
                    chk("base_valid", bv, base_valid_q);
                    if (bv) chk("base_reg", r, base_reg_q);
                    chk("index_valid", 0, index_valid_q);
                    chk("disp", dz, disp_size_q);
                    chk("seg", bv && r == 5, default_seg_q);
                end
            end
        end
    endtask
    task automatic t_cond();
        for (int c = 0; c < 16; c++) begin
            go(8'hc0, 8'h00, {3'b001, c[1], 1'b0}, c[3:0], 32'h0, 1'b0);
            chk("cond_test", c[3:1], cond_test_q);
            chk("cond_negate", c[0], cond_negate_q);
            chk("reg_is_dest", c[1], reg_is_dest_q);
        end
    endtask
    task automatic imm_case(input logic [4:0] c, input logic [31:0] raw, input logic ib,
                            input logic [31:0] e);
        go(8'hc0, 8'h00, c, 4'h0, raw, ib);
        chk("imm", e, imm_q);
    endtask
    task automatic t_imm();
        imm_case(5'b10101, 32'h12345680, 1'b1, 32'h0000ff80);
        imm_case(5'b00101, 32'h12345680, 1'b1, 32'hffffff80);
        imm_case(5'b00101, 32'h1234567f, 1'b1, 32'h0000007f);
        imm_case(5'b00100, 32'h12345680, 1'b1, 32'h00000080);
        imm_case(5'b00001, 32'h12345680, 1'b1, 32'h12345680);
        imm_case(5'b00101, 32'h12345680, 1'b0, 32'h12345680);
    endtask
    task automatic end_sim();
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("out_valid", 0, out_valid_q);
        t_reg16();
        t_ea16();
        t_ea32();
        t_ea32_plain();
        t_cond();
        t_imm();
        end_sim();
    end
    // a run needs under 1000 ns; the margin only guards against a hang
    initial begin
        #20000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
